// >>> logic/tcc_cfg.svh
// register offsets, field positions, reset values for the capture/compare timer
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets (one aligned word each)
// ----------------------------------------------------------------
`define TCC_OFS_CTRL_TWO 8'h00
`define TCC_OFS_CTRL_ONE 8'h04
`define TCC_OFS_STATUS 8'h08
`define TCC_OFS_CAP1_HI 8'h0c
`define TCC_OFS_CAP1_LO 8'h10
`define TCC_OFS_CMP1_HI 8'h14
`define TCC_OFS_CMP1_LO 8'h18
`define TCC_OFS_CNT_HI 8'h1c
`define TCC_OFS_CNT_LO 8'h20
`define TCC_OFS_ACNT_HI 8'h24
`define TCC_OFS_ACNT_LO 8'h28
`define TCC_OFS_CAP2_HI 8'h2c
`define TCC_OFS_CAP2_LO 8'h30
`define TCC_OFS_CMP2_HI 8'h34
`define TCC_OFS_CMP2_LO 8'h38

// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define TCC_ST_CAP1 7
`define TCC_ST_CMP1 6
`define TCC_ST_OVF 5
`define TCC_ST_CAP2 4
`define TCC_ST_CMP2 3

// ----------------------------------------------------------------
// reset values and clock select codes
// ----------------------------------------------------------------
`define TCC_CMP_RESET 16'h8000
`define TCC_CNT_RESET 16'hfffc
`define TCC_CNT_TOP 16'hffff
`define TCC_CC_DIV4 2'h0
`define TCC_CC_DIV2 2'h1
`define TCC_CC_DIV8 2'h2
`define TCC_CC_EXT 2'h3

`endif

// >>> logic/tcc_pkg.sv
// types shared by the capture/compare timer files
package tcc_pkg;

	// control register one, msb first
	typedef struct packed {
		logic capture_irq_enable;
		logic compare_irq_enable;
		logic overflow_irq_enable;
		logic force_output_level_2;
		logic force_output_level_1;
		logic compare_output_level_2;
		logic capture_edge_select_1;
		logic compare_output_level_1;
	} ctrl_one_type;

	// control register two, msb first
	typedef struct packed {
		logic compare_pin_enable_1;
		logic compare_pin_enable_2;
		logic single_pulse_mode;
		logic pwm_mode;
		logic [1:0] clock_select;
		logic capture_edge_select_2;
		logic ext_edge_select;
	} ctrl_two_type;

endpackage

// >>> logic/capture_edge_sync.sv
// capture pin synchroniser and selectable edge detector
`timescale 1ns/1ns
module capture_edge_sync (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic pin,
	input wire logic rising_sel,
	output logic edge_pulse
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// two-flop synchroniser plus history for edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// one-cycle pulse on the chosen transition
	assign edge_pulse = rising_sel ? (sync_r & ~prev_r) : (~sync_r & prev_r);
endmodule

// >>> logic/timer_capture_compare_unit.sv
// capture/compare section of a 16-bit free-running timer, ahb-lite slave
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`include "tcc_cfg.svh"

// Functional notes
// - each capture channel latches the 16-bit counter on its active edge
// - capture registers are read-only; writes leave them unchanged
// - edge select bit per channel, one in each control register
// - capture sets flag; irq when enabled and global mask clear, else pending
// - one capture irq enable covers both capture pins
// - capture flag clears by status read while set then low byte access
// - high byte read blocks capture and flag until low byte read
// - capture register always holds the latest capture value
// - single pulse or pwm mode leaves only capture channel two working
// - capture pins always feed the timer, whatever the pin direction
// - both compare registers compared with the counter each timer clock
// - compare registers read/write, untouched by hardware, reset 8000h
// - match sets flag (not channel one in single pulse or pwm mode, not channel two in pwm mode), drives programmed level; pin latch low in reset
// - pin enable clear: no level driven, interrupt still possible
// - compare flag clears by status read then low byte access; irq gating
// - compare high byte write suspends compare until low byte write
// - divide-by-two matches at value, other clocks at value plus one
// - force bit copies level to pin, no flag and no interrupt
// - force bits ignored in single pulse or pwm mode
// - both clock select bits set selects the external clock
// - counter low or alternate low write reloads counter with fffch
module timer_capture_compare_unit (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [1:0] capture_pin,
	input wire logic ext_clk_pin,
	input wire logic irq_global_mask,
	output logic [1:0] compare_pin_o,
	output logic [1:0] compare_pin_oe,
	output logic timer_irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	tcc_pkg::ctrl_one_type ctrl_one_r;
	tcc_pkg::ctrl_two_type ctrl_two_r;
	logic [15:0] counter_r;
	logic [2:0] presc_r;
	logic ext_prev_r;
	logic [1:0][15:0] cap_r;
	logic [1:0][15:0] cmp_r;
	logic [1:0] icf_r;
	logic [1:0] ocf_r;
	logic [1:0] ic_arm_r;
	logic [1:0] oc_arm_r;
	logic tof_r;
	logic tof_arm_r;
	logic [1:0] cap_inh_r;
	logic [1:0] cmp_inh_r;
	logic [1:0] match_prev_r;
	logic [1:0] pin_lvl_r;
	logic [7:0] cnt_buf_r;
	logic cnt_seq_r;
	logic wr_r;
	logic [7:0] addr_r;
	logic [31:0] hrdata_r;
	logic [31:0] hrdata_nxt;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	// timer tick from clock select, prescaler and external edge
	function automatic logic tick_of(input logic [1:0] cc, input logic [2:0] pr,
		input logic ext_edge);
		logic t;
		t = 1'b0;
		unique case (cc)
			`TCC_CC_DIV2: t = pr[0];
			`TCC_CC_DIV4: t = &pr[1:0];
			`TCC_CC_DIV8: t = &pr;
			`TCC_CC_EXT: t = ext_edge;
		endcase
		return t;
	endfunction

	// address compare used for every bus decode strobe; read data selection cases on haddr
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire ap = hsel & htrans[1] & hready;
	wire rd_ap = ap & ~hwrite;
	wire wr_ap = ap & hwrite;
	wire [7:0] wdata = hwdata[7:0];
	wire rd_status = rd_ap & hit(haddr, `TCC_OFS_STATUS);
	wire rd_cnt_hi = rd_ap & (hit(haddr, `TCC_OFS_CNT_HI) | hit(haddr, `TCC_OFS_ACNT_HI));
	wire rd_cnt_lo = rd_ap & (hit(haddr, `TCC_OFS_CNT_LO) | hit(haddr, `TCC_OFS_ACNT_LO));
	wire acc_cnt_lo = (rd_ap & hit(haddr, `TCC_OFS_CNT_LO)) | (wr_r & hit(addr_r, `TCC_OFS_CNT_LO));
	wire wr_cnt_any = wr_r & (hit(addr_r, `TCC_OFS_CNT_LO) | hit(addr_r, `TCC_OFS_ACNT_LO));
	wire wr_ctrl_one = wr_r & hit(addr_r, `TCC_OFS_CTRL_ONE);
	wire wr_ctrl_two = wr_r & hit(addr_r, `TCC_OFS_CTRL_TWO);
	wire [1:0] rd_cap_hi = {rd_ap & hit(haddr, `TCC_OFS_CAP2_HI),
		rd_ap & hit(haddr, `TCC_OFS_CAP1_HI)};
	wire [1:0] rd_cap_lo = {rd_ap & hit(haddr, `TCC_OFS_CAP2_LO),
		rd_ap & hit(haddr, `TCC_OFS_CAP1_LO)};
	wire [1:0] wr_cap_lo = {wr_r & hit(addr_r, `TCC_OFS_CAP2_LO),
		wr_r & hit(addr_r, `TCC_OFS_CAP1_LO)};
	wire [1:0] wr_cmp_hi = {wr_r & hit(addr_r, `TCC_OFS_CMP2_HI),
		wr_r & hit(addr_r, `TCC_OFS_CMP1_HI)};
	wire [1:0] wr_cmp_lo = {wr_r & hit(addr_r, `TCC_OFS_CMP2_LO),
		wr_r & hit(addr_r, `TCC_OFS_CMP1_LO)};
	wire [1:0] rd_cmp_lo = {rd_ap & hit(haddr, `TCC_OFS_CMP2_LO),
		rd_ap & hit(haddr, `TCC_OFS_CMP1_LO)};
	wire [1:0] cap_lo_acc = rd_cap_lo | wr_cap_lo;
	wire [1:0] cmp_lo_acc = rd_cmp_lo | wr_cmp_lo;

	// ----------------------------------------------------------------
	// mode and clock decode
	// ----------------------------------------------------------------
	wire special_mode = ctrl_two_r.single_pulse_mode | ctrl_two_r.pwm_mode;
	wire ext_sync_edge = ctrl_two_r.ext_edge_select ? (ext_clk_pin & ~ext_prev_r)
		: (~ext_clk_pin & ext_prev_r);
	wire tick = tick_of(ctrl_two_r.clock_select, presc_r, ext_sync_edge);
	wire div2 = ctrl_two_r.clock_select == `TCC_CC_DIV2;
	wire ovf_evt = tick & (counter_r == `TCC_CNT_TOP) & ~wr_cnt_any;
	wire [15:0] counter_nxt = wr_cnt_any ? `TCC_CNT_RESET
		: (tick ? counter_r + 16'h0001 : counter_r);

	// ----------------------------------------------------------------
	// capture path
	// ----------------------------------------------------------------
	logic [1:0] cap_edge;
	wire [1:0] edge_sel = {ctrl_two_r.capture_edge_select_2,
		ctrl_one_r.capture_edge_select_1};

	// one synchroniser per pin, wired regardless of pin direction
	capture_edge_sync u_cap_sync1 (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(capture_pin[0]),
		.rising_sel(edge_sel[0]),
		.edge_pulse(cap_edge[0])
	);
	capture_edge_sync u_cap_sync2 (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(capture_pin[1]),
		.rising_sel(edge_sel[1]),
		.edge_pulse(cap_edge[1])
	);

	// channel one gated off in special modes, both by read inhibit
	wire [1:0] cap_evt = cap_edge & ~cap_inh_r & {1'b1, ~special_mode};

	// ----------------------------------------------------------------
	// compare path
	// ----------------------------------------------------------------
	wire [1:0] match_now;
	assign match_now[0] = counter_r == (div2 ? cmp_r[0] : cmp_r[0] + 16'h0001);
	assign match_now[1] = counter_r == (div2 ? cmp_r[1] : cmp_r[1] + 16'h0001);
	wire [1:0] cmp_evt = match_now & ~match_prev_r & ~cmp_inh_r;
	wire [1:0] ocf_allow = {~ctrl_two_r.pwm_mode, ~special_mode};
	wire [1:0] pin_en = {ctrl_two_r.compare_pin_enable_2, ctrl_two_r.compare_pin_enable_1};
	wire [1:0] olvl = {ctrl_one_r.compare_output_level_2, ctrl_one_r.compare_output_level_1};
	wire [7:0] wr_one = wdata;
	wire [1:0] force_wr = {wr_ctrl_one & wr_one[4], wr_ctrl_one & wr_one[3]}
		& {2{~special_mode}};
	wire [1:0] force_lvl = {wr_one[2], wr_one[0]};

	// ----------------------------------------------------------------
	// flag next values: a set wins over a clear
	// ----------------------------------------------------------------
	wire [1:0] icf_nxt = cap_evt | (icf_r & ~(ic_arm_r & cap_lo_acc));
	wire [1:0] ocf_nxt = (cmp_evt & ocf_allow) | (ocf_r & ~(oc_arm_r & cmp_lo_acc));
	wire tof_nxt = ovf_evt | (tof_r & ~(tof_arm_r & acc_cnt_lo));
	wire [7:0] status_byte = {icf_r[0], ocf_r[0], tof_r, icf_r[1], ocf_r[1], 3'h0};

	// irq pending until enable set and global mask clear
	assign timer_irq = ~irq_global_mask & ((ctrl_one_r.capture_irq_enable & |icf_r)
		| (ctrl_one_r.compare_irq_enable & |ocf_r)
		| (ctrl_one_r.overflow_irq_enable & tof_r));

	// ----------------------------------------------------------------
	// read data selection
	// ----------------------------------------------------------------
	always_comb begin
		hrdata_nxt = 32'h0000_0000;
		unique case (haddr)
			`TCC_OFS_CTRL_TWO: hrdata_nxt[7:0] = ctrl_two_r;
			`TCC_OFS_CTRL_ONE: hrdata_nxt[7:0] = ctrl_one_r & 8'he7;
			`TCC_OFS_STATUS: hrdata_nxt[7:0] = status_byte;
			`TCC_OFS_CAP1_HI: hrdata_nxt[7:0] = cap_r[0][15:8];
			`TCC_OFS_CAP1_LO: hrdata_nxt[7:0] = cap_r[0][7:0];
			`TCC_OFS_CAP2_HI: hrdata_nxt[7:0] = cap_r[1][15:8];
			`TCC_OFS_CAP2_LO: hrdata_nxt[7:0] = cap_r[1][7:0];
			`TCC_OFS_CMP1_HI: hrdata_nxt[7:0] = cmp_r[0][15:8];
			`TCC_OFS_CMP1_LO: hrdata_nxt[7:0] = cmp_r[0][7:0];
			`TCC_OFS_CMP2_HI: hrdata_nxt[7:0] = cmp_r[1][15:8];
			`TCC_OFS_CMP2_LO: hrdata_nxt[7:0] = cmp_r[1][7:0];
			`TCC_OFS_CNT_HI, `TCC_OFS_ACNT_HI: hrdata_nxt[7:0] = counter_r[15:8];
			`TCC_OFS_CNT_LO, `TCC_OFS_ACNT_LO:
				hrdata_nxt[7:0] = cnt_seq_r ? cnt_buf_r : counter_r[7:0];
			default: hrdata_nxt = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// bus slave registers
	// ----------------------------------------------------------------
	// zero wait state; read data registered at address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r <= 1'b0;
			addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else begin
			wr_r <= wr_ap;
			addr_r <= ap ? haddr : addr_r;
			hrdata_r <= rd_ap ? hrdata_nxt : hrdata_r;
		end
	end
	assign hrdata = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ----------------------------------------------------------------
	// control registers, counter and prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_one_r <= '0;
			ctrl_two_r <= '0;
			counter_r <= `TCC_CNT_RESET;
			presc_r <= 3'h0;
			ext_prev_r <= 1'b0;
			cnt_buf_r <= 8'h00;
			cnt_seq_r <= 1'b0;
		end else begin
			ctrl_one_r <= wr_ctrl_one ? tcc_pkg::ctrl_one_type'(wdata) : ctrl_one_r;
			ctrl_two_r <= wr_ctrl_two ? tcc_pkg::ctrl_two_type'(wdata) : ctrl_two_r;
			counter_r <= counter_nxt;
			presc_r <= presc_r + 3'h1;
			ext_prev_r <= ext_clk_pin;
			cnt_buf_r <= rd_cnt_hi ? counter_r[7:0] : cnt_buf_r;
			cnt_seq_r <= rd_cnt_hi | (cnt_seq_r & ~rd_cnt_lo);
		end
	end

	// ----------------------------------------------------------------
	// capture values, inhibit and flags
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_r <= '0;
			cap_inh_r <= 2'h0;
			icf_r <= 2'h0;
			ic_arm_r <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				cap_r[i] <= cap_evt[i] ? counter_r : cap_r[i];
				cap_inh_r[i] <= rd_cap_hi[i] | (cap_inh_r[i] & ~rd_cap_lo[i]);
				ic_arm_r[i] <= rd_status ? icf_r[i] : (ic_arm_r[i] & ~cap_lo_acc[i]);
			end
			icf_r <= icf_nxt;
		end
	end

	// ----------------------------------------------------------------
	// compare values, inhibit, flags and pin latch
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_r <= {`TCC_CMP_RESET, `TCC_CMP_RESET};
			cmp_inh_r <= 2'h0;
			ocf_r <= 2'h0;
			oc_arm_r <= 2'h0;
			match_prev_r <= 2'h0;
			pin_lvl_r <= 2'h0;
			tof_r <= 1'b0;
			tof_arm_r <= 1'b0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_cmp_hi[i]) begin
					cmp_r[i][15:8] <= wdata;
				end
				if (wr_cmp_lo[i]) begin
					cmp_r[i][7:0] <= wdata;
				end
				cmp_inh_r[i] <= wr_cmp_hi[i] | (cmp_inh_r[i] & ~wr_cmp_lo[i]);
				oc_arm_r[i] <= rd_status ? ocf_r[i] : (oc_arm_r[i] & ~cmp_lo_acc[i]);
				if (force_wr[i]) begin
					pin_lvl_r[i] <= force_lvl[i];
				end else if (cmp_evt[i] & pin_en[i]) begin
					pin_lvl_r[i] <= olvl[i];
				end
			end
			match_prev_r <= match_now;
			ocf_r <= ocf_nxt;
			tof_r <= tof_nxt;
			tof_arm_r <= rd_status ? tof_r : (tof_arm_r & ~acc_cnt_lo);
		end
	end

	// pin driven only while its compare pin enable is set
	assign compare_pin_o = pin_lvl_r;
	assign compare_pin_oe = pin_en;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	AST_CAP_LATCH: assert property (cap_evt[0] |=> cap_r[0] == $past(counter_r))
		else $error("capture one did not latch the counter");
	AST_CAP_RO: assert property (!cap_evt[1] |=> $stable(cap_r[1]))
		else $error("capture two changed without a capture event");
	AST_IRQ_MASK: assert property (irq_global_mask |-> !timer_irq)
		else $error("interrupt raised while globally masked");
	AST_CAP_PEND: assert property (icf_r[1] && ctrl_one_r.capture_irq_enable
		&& !irq_global_mask |-> timer_irq)
		else $error("capture two flag did not request interrupt");
	AST_CAP_INH: assert property (rd_cap_hi[0] |=> !cap_evt[0]
		##1 !(icf_r[0] && !$past(icf_r[0])))
		else $error("capture one ran after a high byte read");
	AST_SPECIAL_CAP: assert property (special_mode |-> !cap_evt[0])
		else $error("capture one active in a special mode");
	AST_CMP_INH: assert property (wr_cmp_hi[1] |=> !cmp_evt[1])
		else $error("compare two ran after a high byte write");
	AST_CMP_HOLD: assert property (!wr_r |=> $stable(cmp_r))
		else $error("compare value changed without a bus write");
	AST_PIN_MATCH: assert property (cmp_evt[0] && pin_en[0] && !force_wr[0]
		|=> compare_pin_o[0] == $past(olvl[0]))
		else $error("compare one pin missed its programmed level");
	AST_CNT_RELOAD: assert property (wr_cnt_any |=> counter_r == `TCC_CNT_RESET)
		else $error("counter not reloaded after low byte write");
	AST_CMP_CLR: assert property (oc_arm_r[0] && cmp_lo_acc[0] && !cmp_evt[0]
		|=> !ocf_r[0])
		else $error("compare one flag not cleared by its sequence");
endmodule

// >>> tb/pin_world.sv
// pin-side model: capture signal sources and pulled-up compare pins
`timescale 1ns/1ns
module pin_world (
	input wire logic hclk,
	input wire logic [1:0] compare_pin_o,
	input wire logic [1:0] compare_pin_oe,
	output logic [1:0] capture_pin,
	output logic ext_clk_pin,
	output logic [1:0] pin_level
);
	// ------------------------------------------------------------
	// compare pins: pull-up wins when the timer does not drive
	// ------------------------------------------------------------
	assign pin_level[0] = compare_pin_oe[0] ? compare_pin_o[0] : 1'b1;
	assign pin_level[1] = compare_pin_oe[1] ? compare_pin_o[1] : 1'b1;

	// idle sources at time zero; external clock low until ticked
	initial begin
		capture_pin = 2'h0;
		ext_clk_pin = 1'b0;
	end

	// move one capture source just after a clock edge
	task automatic set_cap(input int ch, input logic lvl);
		@(posedge hclk);
		capture_pin[ch] <= lvl;
	endtask

	// external clock: n rising edges, each level held four cycles
	task automatic ext_ticks(input int n);
		repeat (n) begin
			repeat (4) @(posedge hclk);
			ext_clk_pin <= 1'b1;
			repeat (4) @(posedge hclk);
			ext_clk_pin <= 1'b0;
		end
	endtask
endmodule

// >>> tb/timer_capture_compare_unit_test.sv
// self-checking bench for the capture/compare timer over ahb-lite
`timescale 1ns/1ns
`include "tcc_cfg.svh"
module timer_capture_compare_unit_test;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [1:0] capture_pin;
	logic ext_clk_pin;
	logic irq_global_mask;
	logic [1:0] compare_pin_o;
	logic [1:0] compare_pin_oe;
	logic [1:0] pin_level;
	logic timer_irq;
	logic [15:0] cv;
	logic [15:0] cv2;
	int bad_count;
	int comparisons;

	timer_capture_compare_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.capture_pin(capture_pin), .ext_clk_pin(ext_clk_pin),
		.irq_global_mask(irq_global_mask), .compare_pin_o(compare_pin_o),
		.compare_pin_oe(compare_pin_oe), .timer_irq(timer_irq));

	pin_world i_world (.hclk(hclk), .compare_pin_o(compare_pin_o),
		.compare_pin_oe(compare_pin_oe), .capture_pin(capture_pin),
		.ext_clk_pin(ext_clk_pin), .pin_level(pin_level));

	// ------------------------------------------------------------
	// comparison and closing
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bit_is(input logic seen, input logic exp);
		check({15'h0, seen}, {15'h0, exp});
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// ahb-lite single word transfer, waits on hready both phases
	// ------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
		rd = hrdata[7:0];
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] t;
		xfer(1'b1, a, d, t);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		xfer(1'b0, a, 8'h00, v);
		check({8'h0, v}, {8'h0, e});
	endtask

	// status read with the overflow flag masked off
	task automatic st(input logic [7:0] e);
		logic [7:0] v;
		xfer(1'b0, `TCC_OFS_STATUS, 8'h00, v);
		check({8'h0, v & 8'hdf}, {8'h0, e});
	endtask

	// two-step flag clear: status read, then low byte read
	task automatic clr(input logic [7:0] a);
		logic [7:0] v;
		xfer(1'b0, `TCC_OFS_STATUS, 8'h00, v);
		xfer(1'b0, a, 8'h00, v);
	endtask

	task automatic pulse(input int ch);
		i_world.set_cap(ch, 1'b0);
		i_world.set_cap(ch, 1'b1);
		repeat (6) @(posedge hclk);
	endtask

	task automatic read_cap1(output logic [15:0] v);
		xfer(1'b0, `TCC_OFS_CAP1_HI, 8'h00, v[15:8]);
		xfer(1'b0, `TCC_OFS_CAP1_LO, 8'h00, v[7:0]);
	endtask

	// ------------------------------------------------------------
	// clock and watchdog
	// ------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	initial begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		bad_count = 0;
		comparisons = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		irq_global_mask = 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		// reset values and compare register access
		bit_is(compare_pin_o[0], 1'b0);
		rd(`TCC_OFS_CMP1_HI, 8'h80);
		rd(`TCC_OFS_CMP1_LO, 8'h00);
		st(8'h00);
		wr(`TCC_OFS_CMP2_HI, 8'h12);
		wr(`TCC_OFS_CMP2_LO, 8'h34);
		rd(`TCC_OFS_CMP2_HI, 8'h12);
		rd(`TCC_OFS_CMP2_LO, 8'h34);
		// capture on channel one, rising edge, irq gating
		wr(`TCC_OFS_CTRL_ONE, 8'h82);
		wr(`TCC_OFS_CNT_LO, 8'h00);
		pulse(0);
		read_cap1(cv);
		bit_is(cv >= 16'hfffc, 1'b1);
		bit_is(timer_irq, 1'b1);
		@(posedge hclk) irq_global_mask <= 1'b1;
		@(negedge hclk) bit_is(timer_irq, 1'b0);
		@(posedge hclk) irq_global_mask <= 1'b0;
		@(negedge hclk) bit_is(timer_irq, 1'b1);
		wr(`TCC_OFS_CAP1_LO, 8'h55);
		bit_is(hresp, 1'b0);
		bit_is(hreadyout, 1'b1);
		rd(`TCC_OFS_CAP1_LO, cv[7:0]);
		st(8'h80);
		rd(`TCC_OFS_CAP1_LO, cv[7:0]);
		st(8'h00);
		// high byte read blocks capture until low byte read
		rd(`TCC_OFS_CAP1_HI, cv[15:8]);
		pulse(0);
		st(8'h00);
		rd(`TCC_OFS_CAP1_LO, cv[7:0]);
		pulse(0);
		st(8'h80);
		read_cap1(cv2);
		bit_is(cv2 !== cv, 1'b1);
		clr(`TCC_OFS_CAP1_LO);
		// pwm mode: channel two on falling edge only, channel one off
		wr(`TCC_OFS_CTRL_TWO, 8'h10);
		i_world.set_cap(1, 1'b1);
		repeat (6) @(posedge hclk);
		st(8'h00);
		i_world.set_cap(1, 1'b0);
		pulse(0);
		st(8'h10);
		bit_is(timer_irq, 1'b1);
		clr(`TCC_OFS_CAP2_LO);
		// compare at div2, pin one enabled, channel two suspended
		wr(`TCC_OFS_CTRL_ONE, 8'h45);
		wr(`TCC_OFS_CTRL_TWO, 8'h84);
		wr(`TCC_OFS_CMP1_HI, 8'h00);
		st(8'h00);
		wr(`TCC_OFS_CMP1_LO, 8'h00);
		wr(`TCC_OFS_CMP2_HI, 8'h00);
		@(negedge hclk) bit_is(compare_pin_o[0], 1'b0);
		wr(`TCC_OFS_CNT_LO, 8'h00);
		rd(`TCC_OFS_CNT_HI, 8'hff);
		repeat (20) @(posedge hclk);
		st(8'h40);
		@(negedge hclk) bit_is(compare_pin_o[0], 1'b1);
		bit_is(compare_pin_oe[0], 1'b1);
		bit_is(timer_irq, 1'b1);
		wr(`TCC_OFS_CMP2_LO, 8'h00);
		wr(`TCC_OFS_CNT_LO, 8'h00);
		repeat (20) @(posedge hclk);
		st(8'h48);
		@(negedge hclk) bit_is(compare_pin_oe[1], 1'b0);
		bit_is(pin_level[1], 1'b1);
		bit_is(compare_pin_o[1], 1'b0);
		clr(`TCC_OFS_CMP1_LO);
		clr(`TCC_OFS_CMP2_LO);
		st(8'h00);
		@(negedge hclk) bit_is(timer_irq, 1'b0);
		// forced output level, ignored in pwm mode
		wr(`TCC_OFS_CTRL_ONE, 8'h08);
		@(negedge hclk) bit_is(compare_pin_o[0], 1'b0);
		st(8'h00);
		rd(`TCC_OFS_CTRL_ONE, 8'h00);
		wr(`TCC_OFS_CTRL_TWO, 8'h94);
		wr(`TCC_OFS_CTRL_ONE, 8'h09);
		@(negedge hclk) bit_is(compare_pin_o[0], 1'b0);
		wr(`TCC_OFS_CTRL_TWO, 8'h84);
		wr(`TCC_OFS_CTRL_ONE, 8'h09);
		@(negedge hclk) bit_is(pin_level[0], 1'b1);
		st(8'h00);
		// mid-run reset: pin latch low, compare value back to 8000h
		@(posedge hclk) hresetn <= 1'b0;
		@(negedge hclk) bit_is(compare_pin_o[0], 1'b0);
		@(posedge hclk) hresetn <= 1'b1;
		rd(`TCC_OFS_CMP2_HI, 8'h80);
		// external clock, rising edge: compare matches at value plus one
		wr(`TCC_OFS_CTRL_TWO, 8'h8d);
		wr(`TCC_OFS_CMP1_HI, 8'hff);
		wr(`TCC_OFS_CMP1_LO, 8'hfe);
		wr(`TCC_OFS_CNT_LO, 8'h00);
		i_world.ext_ticks(2);
		st(8'h00);
		i_world.ext_ticks(1);
		st(8'h40);
		rd(`TCC_OFS_CNT_HI, 8'hff);
		rd(`TCC_OFS_CNT_LO, 8'hff);
		wrap_up();
	end
endmodule
